// >>> rtl/t16_pkg.sv
package t16_pkg;

  // Register map, one byte per location
  localparam logic [7:0] ADDR_CNT_LO   = 8'h00;
  localparam logic [7:0] ADDR_CNT_HI   = 8'h01;
  localparam logic [7:0] ADDR_CMP_BASE = 8'h02;
  localparam logic [7:0] ADDR_ACTION   = 8'h06;
  localparam logic [7:0] ADDR_WAVE     = 8'h07;
  localparam logic [7:0] ADDR_FLAGS    = 8'h08;
  localparam logic [7:0] ADDR_IRQ_EN   = 8'h09;
  localparam logic [7:0] ADDR_FORCE    = 8'h0a;
  localparam logic [7:0] ADDR_PORT     = 8'h0b;

  // Field positions
  localparam int FLAG_OVF_BIT  = 0;
  localparam int FLAG_CMP_BIT0 = 1;
  localparam int PORT_DIR_BIT0 = 4;

  // Counter limits
  localparam logic [15:0] CNT_BOTTOM = 16'h0000;
  localparam logic [15:0] CNT_MAX    = 16'hffff;
  localparam logic [15:0] TOP_8BIT   = 16'h00ff;
  localparam logic [15:0] TOP_9BIT   = 16'h01ff;
  localparam logic [15:0] TOP_10BIT  = 16'h03ff;

  // Values after reset
  localparam logic [15:0] CMP_RST  = 16'h0000;
  localparam logic        WAVE_RST = 1'b0;

  typedef enum logic [3:0] {
    M_NORMAL   = 4'h0,
    M_PC8      = 4'h1,
    M_PC9      = 4'h2,
    M_PC10     = 4'h3,
    M_CTC_CMP  = 4'h4,
    M_FAST8    = 4'h5,
    M_FAST9    = 4'h6,
    M_FAST10   = 4'h7,
    M_PFC_CAP  = 4'h8,
    M_PFC_CMP  = 4'h9,
    M_PC_CAP   = 4'ha,
    M_PC_CMP   = 4'hb,
    M_CTC_CAP  = 4'hc,
    M_RSVD     = 4'hd,
    M_FAST_CAP = 4'he,
    M_FAST_CMP = 4'hf
  } t16_mode_t;

  typedef enum logic [1:0] {
    ACT_NONE   = 2'h0,
    ACT_TOGGLE = 2'h1,
    ACT_CLEAR  = 2'h2,
    ACT_SET    = 2'h3
  } t16_act_t;

  typedef enum logic {
    DIR_UP   = 1'b0,
    DIR_DOWN = 1'b1
  } t16_dir_t;

endpackage

// >>> rtl/t16_oc_top.sv
// Function
// - Compare count with each compare value; on equality set that channel's flag.
// - Enabled set compare flag requests interrupt; service acknowledge clears it.
// - Writing one to a compare flag bit clears it; zero leaves it.
// - Channel A compare value can be the counter TOP value.
// - Compare value double buffered in PWM modes, direct in normal and clear-on-match.
// - Buffered value moves to compare register only at TOP or BOTTOM.
// - Compare location accesses reach buffer when buffered, else compare register.
// - Compare value changes only by writes and buffer loads; high byte reads directly.
// - High byte written first into shared latch; low write loads 16 bits.
// - Force strobe in non-PWM modes acts on output as a match, no flag.
// - Counter write suppresses compare matches in the next timer tick.
// - Waveform output resets to zero and keeps value across mode changes.
// - Output action bits unbuffered; govern from first match after write.
// - Nonzero output action makes waveform output replace port value.
// - Output action zero leaves waveform output unchanged on match.
// - Output action never changes counting; only waveform mode does.
// - Mode 0 counts up only and wraps from max to zero.
// - Mode 0 sets overflow flag as counter becomes zero; service clears it.
// - Mode 0 accepts a counter write at any time.
`timescale 1ns/10ps
module t16_oc_top #(
  parameter int NCH = 2
) (
  // Clock and reset
  input  wire logic           mclk,
  input  wire logic           nrst,
  // Timer tick from the prescaler, same clock domain
  input  wire logic           timer_tick,
  // TOP source from the capture unit
  input  wire logic [15:0]    capture_value,
  // Register port
  input  wire logic [7:0]     reg_addr,
  input  wire logic [7:0]     reg_wdata,
  input  wire logic           reg_wr,
  input  wire logic           reg_rd,
  output logic      [7:0]     reg_rdata_r,
  // Interrupt requests and service acknowledges, bit 0 overflow
  input  wire logic [NCH:0]   irq_ack,
  output logic      [NCH:0]   irq_req_r,
  // Port pins
  output logic      [NCH-1:0] pin_out_r,
  output logic      [NCH-1:0] pin_oe_r
);

  // Compare locations 02h to 05h, below the action location, leave room for two channels only
  if (NCH < 1 || NCH > 2) begin : g_bad_nch
    $error("NCH must be 1 or 2");
  end

  logic [15:0]          timer_count_r;
  logic [15:0]          timer_count_nxt;
  logic [7:0]           temp_r;
  t16_pkg::t16_dir_t    dir_r;
  t16_pkg::t16_dir_t    dir_nxt;
  logic                 block_r;
  t16_pkg::t16_mode_t   waveform_select_r;
  logic [1:0]           output_action_select_r [NCH];
  logic [15:0]          compare_value_r [NCH];
  logic [15:0]          compare_buf_r [NCH];
  logic [NCH-1:0]       compare_flag_r;
  logic [NCH-1:0]       compare_flag_nxt;
  logic [NCH-1:0]       compare_irq_enable_r;
  logic [NCH-1:0]       wave_r;
  logic [NCH-1:0]       port_val_r;
  logic [NCH-1:0]       pin_direction_bit_r;
  logic [NCH-1:0]       match;
  logic [NCH-1:0]       wr_cmp_hi;
  logic                 overflow_flag_r;
  logic                 overflow_flag_nxt;
  logic                 ovf_irq_enable_r;
  logic                 is_pwm;
  logic                 is_fast;
  logic                 is_pfc;
  logic                 is_ctc;
  logic [15:0]          top_val;
  logic                 at_top;
  logic                 at_bot;
  logic                 upd;
  logic                 ovf_evt;
  logic                 wr_cnt_lo;
  logic                 wr_cnt_hi;
  logic                 wr_flags;
  logic                 wr_force;
  logic [7:0]           rd_data;

  assign wr_cnt_lo = reg_wr && (reg_addr == t16_pkg::ADDR_CNT_LO);
  assign wr_cnt_hi = reg_wr && (reg_addr == t16_pkg::ADDR_CNT_HI);
  assign wr_flags  = reg_wr && (reg_addr == t16_pkg::ADDR_FLAGS);
  assign wr_force  = reg_wr && (reg_addr == t16_pkg::ADDR_FORCE);

  // Mode classes; output action bits play no part here
  always_comb begin
    is_ctc  = (waveform_select_r == t16_pkg::M_CTC_CMP)
           || (waveform_select_r == t16_pkg::M_CTC_CAP);
    is_pwm  = !(is_ctc || waveform_select_r == t16_pkg::M_NORMAL);
    is_fast = (waveform_select_r == t16_pkg::M_FAST8)
           || (waveform_select_r == t16_pkg::M_FAST9)
           || (waveform_select_r == t16_pkg::M_FAST10)
           || (waveform_select_r == t16_pkg::M_FAST_CAP)
           || (waveform_select_r == t16_pkg::M_FAST_CMP);
    is_pfc  = (waveform_select_r == t16_pkg::M_PFC_CAP)
           || (waveform_select_r == t16_pkg::M_PFC_CMP);
  end

  // TOP selection
  always_comb begin
    case (waveform_select_r)
      t16_pkg::M_PC8, t16_pkg::M_FAST8:       top_val = t16_pkg::TOP_8BIT;
      t16_pkg::M_PC9, t16_pkg::M_FAST9:       top_val = t16_pkg::TOP_9BIT;
      t16_pkg::M_PC10, t16_pkg::M_FAST10:     top_val = t16_pkg::TOP_10BIT;
      t16_pkg::M_CTC_CMP, t16_pkg::M_PFC_CMP,
      t16_pkg::M_PC_CMP, t16_pkg::M_FAST_CMP: top_val = compare_value_r[0];
      t16_pkg::M_PFC_CAP, t16_pkg::M_PC_CAP,
      t16_pkg::M_CTC_CAP, t16_pkg::M_FAST_CAP: top_val = capture_value;
      default:                                top_val = t16_pkg::CNT_MAX;
    endcase
  end

  assign at_top = (timer_count_r == top_val);
  assign at_bot = (timer_count_r == t16_pkg::CNT_BOTTOM);
  // Double buffer load point
  assign upd = timer_tick && is_pwm && (is_pfc ? at_bot : at_top);

  // Counting sequence
  always_comb begin
    timer_count_nxt = timer_count_r + 16'h0001;
    dir_nxt         = dir_r;
    if (!is_pwm) begin
      if (is_ctc && at_top) begin
        timer_count_nxt = t16_pkg::CNT_BOTTOM;
      end
    end else if (is_fast) begin
      if (at_top) begin
        timer_count_nxt = t16_pkg::CNT_BOTTOM;
      end
    end else if (dir_r == t16_pkg::DIR_UP) begin
      if (at_top) begin
        timer_count_nxt = timer_count_r - 16'h0001;
        dir_nxt         = t16_pkg::DIR_DOWN;
      end
    end else begin
      if (at_bot) begin
        dir_nxt = t16_pkg::DIR_UP;
      end else begin
        timer_count_nxt = timer_count_r - 16'h0001;
      end
    end
  end

  // Processor write wins over counting, in any mode
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      timer_count_r <= t16_pkg::CNT_BOTTOM;
      dir_r         <= t16_pkg::DIR_UP;
    end else if (wr_cnt_lo) begin
      timer_count_r <= {temp_r, reg_wdata};
    end else if (timer_tick) begin
      timer_count_r <= timer_count_nxt;
      dir_r         <= dir_nxt;
    end
  end

  // Match blocking after a counter write, held until the next tick
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      block_r <= 1'b0;
    end else if (wr_cnt_lo) begin
      block_r <= 1'b1;
    end else if (timer_tick) begin
      block_r <= 1'b0;
    end
  end

  // Shared high-byte latch
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      temp_r <= 8'h00;
    end else if (wr_cnt_hi || (|wr_cmp_hi)) begin
      temp_r <= reg_wdata;
    end else if (reg_rd && reg_addr == t16_pkg::ADDR_CNT_LO) begin
      temp_r <= timer_count_r[15:8];
    end
  end

  // Mode setting, taking effect at once
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      waveform_select_r <= t16_pkg::M_NORMAL;
    end else if (reg_wr && reg_addr == t16_pkg::ADDR_WAVE) begin
      waveform_select_r <= t16_pkg::t16_mode_t'(reg_wdata[3:0]);
    end
  end

  // Enables and port control
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      compare_irq_enable_r <= '0;
      ovf_irq_enable_r     <= 1'b0;
      port_val_r           <= '0;
      pin_direction_bit_r  <= '0;
    end else if (reg_wr && reg_addr == t16_pkg::ADDR_IRQ_EN) begin
      ovf_irq_enable_r     <= reg_wdata[t16_pkg::FLAG_OVF_BIT];
      compare_irq_enable_r <= reg_wdata[t16_pkg::FLAG_CMP_BIT0 +: NCH];
    end else if (reg_wr && reg_addr == t16_pkg::ADDR_PORT) begin
      port_val_r          <= reg_wdata[NCH-1:0];
      pin_direction_bit_r <= reg_wdata[t16_pkg::PORT_DIR_BIT0 +: NCH];
    end
  end

  // Overflow event per mode
  assign ovf_evt = timer_tick && (is_pwm
                 ? (is_fast ? at_top : (at_bot && dir_r == t16_pkg::DIR_DOWN))
                 : (timer_count_r == t16_pkg::CNT_MAX));

  // Set wins over clear
  always_comb begin
    overflow_flag_nxt = overflow_flag_r;
    if (irq_ack[0] || (wr_flags && reg_wdata[t16_pkg::FLAG_OVF_BIT])) begin
      overflow_flag_nxt = 1'b0;
    end
    if (ovf_evt) begin
      overflow_flag_nxt = 1'b1;
    end
  end

  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      overflow_flag_r <= 1'b0;
    end else begin
      overflow_flag_r <= overflow_flag_nxt;
    end
  end

  genvar gi;
  generate
    for (gi = 0; gi < NCH; gi++) begin : g_ch
      localparam logic [7:0] LO_ADDR = t16_pkg::ADDR_CMP_BASE + 8'(2 * gi);
      localparam logic [7:0] HI_ADDR = t16_pkg::ADDR_CMP_BASE + 8'(2 * gi + 1);
      logic           wr_lo;
      logic           frc;
      logic           act_evt;
      logic           wave_nxt;
      t16_pkg::t16_act_t act;

      assign wr_lo         = reg_wr && (reg_addr == LO_ADDR);
      assign wr_cmp_hi[gi] = reg_wr && (reg_addr == HI_ADDR);
      assign act           = t16_pkg::t16_act_t'(output_action_select_r[gi]);
      assign match[gi]     = timer_tick && !block_r
                          && (timer_count_r == compare_value_r[gi]);
      assign frc           = wr_force && reg_wdata[gi] && !is_pwm;
      assign act_evt       = match[gi] || frc;

      // Compare and buffer registers change only by writes and loads
      always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
          compare_value_r[gi] <= t16_pkg::CMP_RST;
          compare_buf_r[gi]   <= t16_pkg::CMP_RST;
        end else if (wr_lo) begin
          compare_buf_r[gi] <= {temp_r, reg_wdata};
          if (!is_pwm) begin
            compare_value_r[gi] <= {temp_r, reg_wdata};
          end
        end else if (upd) begin
          compare_value_r[gi] <= compare_buf_r[gi];
        end
      end

      always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
          output_action_select_r[gi] <= 2'h0;
        end else if (reg_wr && reg_addr == t16_pkg::ADDR_ACTION) begin
          output_action_select_r[gi] <= reg_wdata[2*gi +: 2];
        end
      end

      always_comb begin
        compare_flag_nxt[gi] = compare_flag_r[gi];
        if (irq_ack[gi+1]) begin
          compare_flag_nxt[gi] = 1'b0;
        end
        if (wr_flags && reg_wdata[t16_pkg::FLAG_CMP_BIT0 + gi]) begin
          compare_flag_nxt[gi] = 1'b0;
        end
        if (match[gi]) begin
          compare_flag_nxt[gi] = 1'b1;
        end
      end

      // Waveform generator per mode class
      always_comb begin
        wave_nxt = wave_r[gi];
        if (!is_pwm) begin
          if (act_evt) begin
            case (act)
              t16_pkg::ACT_TOGGLE: wave_nxt = !wave_r[gi];
              t16_pkg::ACT_CLEAR:  wave_nxt = 1'b0;
              t16_pkg::ACT_SET:    wave_nxt = 1'b1;
              default:             wave_nxt = wave_r[gi];
            endcase
          end
        end else if (act == t16_pkg::ACT_TOGGLE) begin
          if (match[gi] && gi == 0 && (waveform_select_r == t16_pkg::M_FAST_CMP
              || waveform_select_r == t16_pkg::M_PFC_CMP
              || waveform_select_r == t16_pkg::M_PC_CMP)) begin
            wave_nxt = !wave_r[gi];
          end
        end else if (act != t16_pkg::ACT_NONE) begin
          if (is_fast) begin
            if (match[gi]) begin
              wave_nxt = (act == t16_pkg::ACT_CLEAR);
            end else if (timer_tick && at_top) begin
              wave_nxt = (act == t16_pkg::ACT_SET);
            end
          end else if (match[gi]) begin
            wave_nxt = (dir_r == t16_pkg::DIR_DOWN) ^ (act == t16_pkg::ACT_SET);
          end
        end
      end

      // Output state survives mode changes
      always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
          wave_r[gi]         <= t16_pkg::WAVE_RST;
          compare_flag_r[gi] <= 1'b0;
        end else begin
          wave_r[gi]         <= wave_nxt;
          compare_flag_r[gi] <= compare_flag_nxt[gi];
        end
      end

      // Pin override; direction stays with the port
      always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
          pin_out_r[gi] <= 1'b0;
          pin_oe_r[gi]  <= 1'b0;
        end else begin
          pin_out_r[gi] <= (act != t16_pkg::ACT_NONE) ? wave_r[gi] : port_val_r[gi];
          pin_oe_r[gi]  <= pin_direction_bit_r[gi];
        end
      end
    end
  endgenerate

  // Interrupt requests follow flag and enable
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      irq_req_r <= '0;
    end else begin
      irq_req_r <= {compare_flag_r & compare_irq_enable_r,
                    overflow_flag_r & ovf_irq_enable_r};
    end
  end

  // Read multiplexer
  always_comb begin
    rd_data = 8'h00;
    case (reg_addr)
      t16_pkg::ADDR_CNT_LO: rd_data = timer_count_r[7:0];
      t16_pkg::ADDR_CNT_HI: rd_data = temp_r;
      t16_pkg::ADDR_WAVE:   rd_data = {4'h0, waveform_select_r};
      t16_pkg::ADDR_FLAGS:  rd_data[NCH:0] = {compare_flag_r, overflow_flag_r};
      t16_pkg::ADDR_IRQ_EN: rd_data[NCH:0] = {compare_irq_enable_r, ovf_irq_enable_r};
      t16_pkg::ADDR_PORT: begin
        rd_data[NCH-1:0]                        = port_val_r;
        rd_data[t16_pkg::PORT_DIR_BIT0 +: NCH]  = pin_direction_bit_r;
      end
      default: rd_data = 8'h00;
    endcase
    for (int i = 0; i < NCH; i++) begin
      if (reg_addr == t16_pkg::ADDR_ACTION) begin
        rd_data[2*i +: 2] = output_action_select_r[i];
      end
      if (reg_addr == t16_pkg::ADDR_CMP_BASE + 8'(2 * i)) begin
        rd_data = is_pwm ? compare_buf_r[i][7:0] : compare_value_r[i][7:0];
      end
      if (reg_addr == t16_pkg::ADDR_CMP_BASE + 8'(2 * i + 1)) begin
        rd_data = is_pwm ? compare_buf_r[i][15:8] : compare_value_r[i][15:8];
      end
    end
  end

  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      reg_rdata_r <= 8'h00;
    end else begin
      reg_rdata_r <= reg_rd ? rd_data : 8'h00;
    end
  end

endmodule

// >>> verif/t16_oc_chk.sv
`timescale 1ns/10ps
module t16_oc_chk #(
  parameter int NCH = 2
) (
  // Clock and reset
  input wire logic           mclk,
  input wire logic           nrst,
  // Timer and capture
  input wire logic           timer_tick,
  input wire logic [15:0]    capture_value,
  // Register port
  input wire logic [7:0]     reg_addr,
  input wire logic [7:0]     reg_wdata,
  input wire logic           reg_wr,
  input wire logic           reg_rd,
  input wire logic [7:0]     reg_rdata_r,
  // Interrupts
  input wire logic [NCH:0]   irq_ack,
  input wire logic [NCH:0]   irq_req_r,
  // Pins
  input wire logic [NCH-1:0] pin_out_r,
  input wire logic [NCH-1:0] pin_oe_r
);
  logic [3:0] act_r;
  logic [5:0] port_r;

  // Shadows of the action and port registers
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      act_r <= 4'h0;
    end else if (reg_wr && reg_addr == t16_pkg::ADDR_ACTION) begin
      act_r <= reg_wdata[3:0];
    end
  end

  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      port_r <= 6'h00;
    end else if (reg_wr && reg_addr == t16_pkg::ADDR_PORT) begin
      port_r <= reg_wdata[5:0];
    end
  end

  default clocking @(posedge mclk); endclocking
  default disable iff (!nrst);

  sequence s_read;
    reg_rd ##1 !reg_rd;
  endsequence

  sequence s_en_off;
    reg_wr && reg_addr == t16_pkg::ADDR_IRQ_EN && reg_wdata == 8'h00;
  endsequence

  chk_rdata_cause: assert property (reg_rdata_r != 8'h00 |-> $past(reg_rd))
    else $error("read data without a read");
  chk_rdata_one: assert property (s_read |=> reg_rdata_r == 8'h00)
    else $error("read data held too long");
  chk_unmapped_zero: assert property (reg_rd && reg_addr > t16_pkg::ADDR_PORT |=>
    reg_rdata_r == 8'h00) else $error("unmapped read not zero");
  chk_force_reads: assert property (reg_rd && reg_addr == t16_pkg::ADDR_FORCE |=>
    reg_rdata_r == 8'h00) else $error("force location read not zero");
  chk_irq_off: assert property (s_en_off |-> ##2 irq_req_r == '0)
    else $error("request with enables off");
  chk_port_a: assert property ($past(act_r[1:0]) == 2'h0 |->
    pin_out_r[0] == $past(port_r[0])) else $error("pin a not port value");
  chk_port_b: assert property ($past(act_r[3:2]) == 2'h0 |->
    pin_out_r[1] == $past(port_r[1])) else $error("pin b not port value");
  chk_oe_dir: assert property (pin_oe_r == $past(port_r[t16_pkg::PORT_DIR_BIT0 +: NCH]))
    else $error("enable not direction bits");
endmodule

bind t16_oc_top t16_oc_chk #(.NCH(NCH)) u_chk (
  .mclk(mclk), .nrst(nrst), .timer_tick(timer_tick), .capture_value(capture_value),
  .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
  .reg_rdata_r(reg_rdata_r), .irq_ack(irq_ack), .irq_req_r(irq_req_r),
  .pin_out_r(pin_out_r), .pin_oe_r(pin_oe_r)
);

// >>> verif/t16_oc_top_tb_top.sv
`timescale 1ns/10ps
module t16_oc_top_tb_top;
  typedef struct packed {logic [7:0] a; logic [7:0] d; logic [7:0] e;} t16_row_t;
  logic        mclk = 1'b0;
  logic        nrst = 1'b0;
  logic        timer_tick = 1'b0;
  logic [15:0] capture_value = 16'h0000;
  logic [7:0]  reg_addr = 8'h00;
  logic [7:0]  reg_wdata = 8'h00;
  logic        reg_wr = 1'b0;
  logic        reg_rd = 1'b0;
  logic [7:0]  reg_rdata_r;
  logic [2:0]  irq_ack = 3'h0;
  logic [2:0]  irq_req_r;
  logic [1:0]  pin_out_r;
  logic [1:0]  pin_oe_r;
  int          errors = 0;
  int          num_checks = 0;
  int          cyc = 0;
  t16_row_t    rows [0:8] = '{{8'h09, 8'h05, 8'h05}, {8'h09, 8'h00, 8'h00},
    {8'h07, 8'h00, 8'h00}, {8'h0a, 8'h01, 8'h00}, {8'h0c, 8'h5a, 8'h00},
    {8'hff, 8'h5a, 8'h00}, {8'h06, 8'h0c, 8'h0c}, {8'h06, 8'h00, 8'h00},
    {8'h0b, 8'h30, 8'h30}};

  t16_oc_top #(.NCH(2)) u_t16_oc_top (
    .mclk(mclk), .nrst(nrst), .timer_tick(timer_tick), .capture_value(capture_value),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata_r(reg_rdata_r), .irq_ack(irq_ack), .irq_req_r(irq_req_r),
    .pin_out_r(pin_out_r), .pin_oe_r(pin_oe_r)
  );

  always #10 mclk = ~mclk;

  task summarize;
    $display("checks %0d errors %0d", num_checks, errors);
    if (errors == 0 && num_checks > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask

  always @(posedge mclk) begin
    cyc <= cyc + 1;
    if (cyc == 5000) begin
      errors = errors + 1;
      $display("MISMATCH t=%0t timeout", $time);
      summarize();
    end
  end

  task chk(input logic [7:0] got, input logic [7:0] exp, input string what);
    num_checks++;
    if (got !== exp) begin
      errors++;
      $display("MISMATCH t=%0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask

  task wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge mclk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge mclk);
    reg_wr <= 1'b0;
  endtask

  task rd(input logic [7:0] a, input logic [7:0] e);
    @(posedge mclk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge mclk);
    reg_rd <= 1'b0;
    #1 chk(reg_rdata_r, e, "read");
  endtask

  // High byte first, then low byte loads all 16 bits
  task w16(input logic [7:0] a, input logic [15:0] v);
    wr(a + 8'h01, v[15:8]);
    wr(a, v[7:0]);
  endtask

  task tk(input int n);
    @(posedge mclk) timer_tick <= 1'b1;
    repeat (n) @(posedge mclk);
    timer_tick <= 1'b0;
  endtask

  task pins(input logic [7:0] e);
    repeat (2) @(posedge mclk);
    #1 chk({6'h00, pin_out_r}, e, "pins");
  endtask

  initial begin
    repeat (12) @(posedge mclk);
    nrst <= 1'b1;
    #1 chk({1'b0, irq_req_r, pin_out_r, pin_oe_r}, 8'h00, "reset outputs");
    foreach (rows[i]) begin
      wr(rows[i].a, rows[i].d);
      rd(rows[i].a, rows[i].e);
    end
    $display("test registers done");
    w16(8'h02, 16'h0005);
    rd(8'h02, 8'h05);
    rd(8'h03, 8'h00);
    w16(8'h00, 16'h0005);
    tk(1);
    rd(8'h08, 8'h00);
    rd(8'h00, 8'h06);
    rd(8'h01, 8'h00);
    w16(8'h00, 16'h0004);
    tk(1);
    rd(8'h08, 8'h00);
    tk(1);
    rd(8'h08, 8'h02);
    wr(8'h09, 8'h02);
    repeat (3) @(posedge mclk);
    #1 chk({5'h00, irq_req_r}, 8'h02, "irq request");
    @(posedge mclk) irq_ack <= 3'h2;
    @(posedge mclk) irq_ack <= 3'h0;
    repeat (3) @(posedge mclk);
    #1 chk({5'h00, irq_req_r}, 8'h00, "irq serviced");
    rd(8'h08, 8'h00);
    wr(8'h09, 8'h00);
    w16(8'h00, 16'h0004);
    tk(2);
    wr(8'h08, 8'h00);
    rd(8'h08, 8'h02);
    wr(8'h08, 8'h02);
    rd(8'h08, 8'h00);
    w16(8'h00, 16'hfffe);
    tk(2);
    rd(8'h08, 8'h01);
    rd(8'h00, 8'h00);
    wr(8'h08, 8'h01);
    $display("test compare done");
    wr(8'h06, 8'h01);
    wr(8'h0a, 8'h01);
    pins(8'h01);
    rd(8'h08, 8'h00);
    wr(8'h0b, 8'h32);
    pins(8'h03);
    wr(8'h07, 8'h05);
    wr(8'h0a, 8'h01);
    wr(8'h07, 8'h00);
    pins(8'h03);
    for (int k = 2; k < 4; k++) begin
      wr(8'h06, 8'(k));
      wr(8'h0a, 8'h01);
      pins({7'h00, k == 3} | 8'h02);
    end
    wr(8'h06, 8'h00);
    wr(8'h0a, 8'h01);
    pins(8'h02);
    wr(8'h06, 8'h02);
    pins(8'h03);
    $display("test pins done");
    wr(8'h06, 8'h00);
    wr(8'h07, 8'h05);
    w16(8'h02, 16'h0010);
    rd(8'h02, 8'h10);
    w16(8'h00, 16'h000e);
    wr(8'h08, 8'h07);
    tk(3);
    rd(8'h08, 8'h00);
    tk(256);
    rd(8'h08, 8'h07);
    $display("test buffering done");
    // Clear-on-match with channel A as TOP: 0,1,2,3 then back to 0 and on to 1
    wr(8'h07, 8'h04);
    w16(8'h02, 16'h0003);
    w16(8'h00, 16'h0000);
    tk(5);
    rd(8'h00, 8'h01);
    $display("test top select done");
    @(posedge mclk) nrst <= 1'b0;
    #1 chk({1'b0, irq_req_r, pin_out_r, pin_oe_r}, 8'h00, "mid reset");
    @(posedge mclk) nrst <= 1'b1;
    rd(8'h07, 8'h00);
    $display("test reset again done");
    summarize();
  end
endmodule
